/* hw/sbsc_mem.sv */
// sram core: lane-writable array with registered read data
// assumes address, lane enables and write data valid at the clock edge
`default_nettype none
module sbsc_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [sbsc_pkg::LANES-1:0] lane_en,
	input wire logic [sbsc_pkg::ADDR_W-1:0] addr,
	input wire logic [sbsc_pkg::WORD_W-1:0] wdata,
	output logic [sbsc_pkg::WORD_W-1:0] rdata
);
	logic [sbsc_pkg::WORD_W-1:0] array [0:(1 << sbsc_pkg::ADDR_W)-1];

	// read before write: a write cycle returns the old word at its address
	always_ff @(posedge clk) begin
		for (int i = 0; i < sbsc_pkg::LANES; i++) begin
			if (we && lane_en[i]) begin
				array[addr][i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] <=
					wdata[i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];
			end
		end
		rdata <= array[addr];
	end
endmodule // sbsc_mem
`default_nettype wire

/* hw/sbsc_pkg.sv */
// constants and carriers of the burst sram control block
// assumes one 50 mhz clock shared with the bus master driving the pins
`default_nettype none
package sbsc_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = 32;
	localparam int WORD_W = LANES * LANE_W;
	localparam int LOW_W = 2;
	// ****************************************
	// reset values and burst steps
	// ****************************************
	localparam logic [LOW_W-1:0] COUNT_RST = 2'h0;
	localparam logic [LOW_W-1:0] COUNT_STEP = 2'h1;
	localparam logic [LANES-1:0] LANES_ALL = 4'hf;
	// parity c and d exist only in the 36-bit configuration
	localparam logic [LANES-1:0] LANES_X18 = 4'h3;

	typedef struct packed {
		logic chip_enable_n;
		logic proc_addr_strobe_n;
		logic ctrl_addr_strobe_n;
		logic burst_step_n;
		logic lane_write_gate_n;
		logic all_lanes_write_n;
		logic [LANES-1:0] byte_lane_write_n;
	} sbsc_ctrl_t;

	typedef struct packed {
		logic [LANES-1:0] parity_lanes;
		logic [DATA_W-1:0] data_lanes;
	} sbsc_word_t;
endpackage : sbsc_pkg
`default_nettype wire

/* hw/sbsc_top.sv */
// burst sram control: strobe decode, burst counter, lane writes, output gating
// assumes every control pin is driven from logic on clk; out_enable_n is asynchronous
// Function
// - chip disabled with controller strobe deselects
// - processor strobe with chip enabled always starts a read burst
// - controller strobe starts write or read burst
// - burst step high holds the address
// - processor strobe ignored while chip disabled
// - read data driven only while enable low
// - controls sampled on edge; enable acts asynchronously
// - gated lane strobe or all-lanes means write
// - no active write control means read
// - each strobe writes its byte and parity; with CFG_X36 low, strobes c, d write neither byte nor parity
// - parity lanes c, d only when 36-bit
// - data pins undriven from reset
// - order high gives interleaved low address
// - order low gives linear low address
// - order pin defaults to interleaved
// - write completes in one edge, self-timed
`default_nettype none
module sbsc_top #(
	parameter bit CFG_X36 = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire sbsc_pkg::sbsc_ctrl_t ctrl,
	input wire logic [sbsc_pkg::ADDR_W-1:0] ext_addr,
	input wire logic burst_order,
	input wire logic out_enable_n,
	input wire sbsc_pkg::sbsc_word_t dq_in,
	output sbsc_pkg::sbsc_word_t dq_out,
	output logic dq_oe
);
	// ****************************************
	// cycle decode
	// ****************************************
	logic [sbsc_pkg::ADDR_W-1:0] base_reg, base_next;
	logic [sbsc_pkg::LOW_W-1:0] start_low_reg, start_low_next;
	logic [sbsc_pkg::LOW_W-1:0] count_reg, count_next;
	logic active_reg, active_next;
	logic read_active_reg, read_active_next;
	logic [sbsc_pkg::WORD_W-1:0] mem_rdata;

	wire logic ce_on = ~ctrl.chip_enable_n;
	wire logic start_proc = ce_on & ~ctrl.proc_addr_strobe_n;
	wire logic start_ctrl = ce_on & ctrl.proc_addr_strobe_n & ~ctrl.ctrl_addr_strobe_n;
	wire logic deselect = ~ce_on & ~ctrl.ctrl_addr_strobe_n;
	// processor strobe masked by chip enable
	wire logic cont = ctrl.ctrl_addr_strobe_n & (ctrl.proc_addr_strobe_n | ~ce_on);
	wire logic start = start_proc | start_ctrl;
	wire logic write_dec = (~ctrl.lane_write_gate_n & ~(&ctrl.byte_lane_write_n))
		| ~ctrl.all_lanes_write_n;
	// a continue with no burst open stays deselected
	wire logic access = start | (cont & active_reg);
	// read unless decoded write; processor start never writes
	wire logic do_write = access & write_dec & ~start_proc;

	// ****************************************
	// burst counter and address
	// ****************************************
	// advance; hold; 2-bit wrap
	wire logic [sbsc_pkg::LOW_W-1:0] count_adv = count_reg + sbsc_pkg::COUNT_STEP;
	wire logic [sbsc_pkg::LOW_W-1:0] count_sel = ctrl.burst_step_n ? count_reg : count_adv;
	// interleave; linear add; order pin high default
	wire logic [sbsc_pkg::LOW_W-1:0] low_seq = burst_order ?
		(start_low_reg ^ count_sel) : (start_low_reg + count_sel);
	wire logic [sbsc_pkg::ADDR_W-1:0] acc_addr = start ? ext_addr :
		{base_reg[sbsc_pkg::ADDR_W-1:sbsc_pkg::LOW_W], low_seq};

	assign base_next = start ? ext_addr : base_reg;
	assign start_low_next = start ? ext_addr[sbsc_pkg::LOW_W-1:0] : start_low_reg;
	assign count_next = start ? sbsc_pkg::COUNT_RST : (access ? count_sel : count_reg);
	assign active_next = start | (active_reg & ~deselect);
	assign read_active_next = access & ~do_write & ~deselect;

	// ****************************************
	// lane enables and write data
	// ****************************************
	// 18-bit configuration: lanes c, d (byte and parity) never written; parity c, d read as 0
	wire logic [sbsc_pkg::LANES-1:0] lane_cfg = CFG_X36 ?
		sbsc_pkg::LANES_ALL : sbsc_pkg::LANES_X18;
	wire logic [sbsc_pkg::LANES-1:0] lane_en = lane_cfg &
		(~ctrl.all_lanes_write_n ? sbsc_pkg::LANES_ALL : ~ctrl.byte_lane_write_n);
	logic [sbsc_pkg::WORD_W-1:0] wpack;
	logic [sbsc_pkg::DATA_W-1:0] rdata_lanes;
	logic [sbsc_pkg::LANES-1:0] rpar_lanes;
	for (genvar i = 0; i < sbsc_pkg::LANES; i++) begin : g_lane
		assign wpack[i*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] =
			{dq_in.parity_lanes[i], dq_in.data_lanes[i*8 +: 8]};
		assign rdata_lanes[i*8 +: 8] = mem_rdata[i*sbsc_pkg::LANE_W +: 8];
		assign rpar_lanes[i] = mem_rdata[i*sbsc_pkg::LANE_W + 8] & lane_cfg[i];
	end

	// write lands on this one edge, no later strobe
	sbsc_mem u_mem (
		.clk(clk),
		.we(do_write),
		.lane_en(lane_en),
		.addr(acc_addr),
		.wdata(wpack),
		.rdata(mem_rdata)
	);

	// ****************************************
	// state and output drive
	// ****************************************
	// all controls taken on the rising edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			base_reg <= '0;
			start_low_reg <= sbsc_pkg::COUNT_RST;
			count_reg <= sbsc_pkg::COUNT_RST;
			active_reg <= 1'b0;
			read_active_reg <= 1'b0;
		end else begin
			base_reg <= base_next;
			start_low_reg <= start_low_next;
			count_reg <= count_next;
			active_reg <= active_next;
			read_active_reg <= read_active_next;
		end
	end

	assign dq_out = {rpar_lanes, rdata_lanes};
	// enable gates drivers without the clock; idle after reset
	assign dq_oe = read_active_reg & ~out_enable_n;

	// ****************************************
	// checks
	// ****************************************
	// last accessed address, held apart from the burst counter so that
	// the order checks below do not lean on the logic they guard
	logic [sbsc_pkg::ADDR_W-1:0] last_addr_reg, last_addr_next;
	wire logic [sbsc_pkg::LOW_W-1:0] acc_low = acc_addr[sbsc_pkg::LOW_W-1:0];
	wire logic [sbsc_pkg::LOW_W-1:0] last_low = last_addr_reg[sbsc_pkg::LOW_W-1:0];

	assign last_addr_next = access ? acc_addr : last_addr_reg;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			last_addr_reg <= '0;
		end else begin
			last_addr_reg <= last_addr_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_deselect_quiet: assert property (deselect |=> !dq_oe)
		else $error("data driven after deselect");
	a_proc_read: assert property (start_proc |-> !do_write ##1 read_active_reg)
		else $error("processor start not a read");
	a_ctrl_write: assert property (start_ctrl && write_dec
		|-> do_write && acc_addr == ext_addr)
		else $error("controller write start wrong");
	a_burst_advance: assert property (cont && active_reg && !ctrl.burst_step_n
		|=> count_reg == 2'($past(count_reg) + sbsc_pkg::COUNT_STEP))
		else $error("burst did not advance");
	a_burst_hold: assert property (cont && ctrl.burst_step_n |=> $stable(count_reg)
		&& $stable(base_reg))
		else $error("suspend moved the address");
	a_ce_masks_proc: assert property (!ce_on && !ctrl.proc_addr_strobe_n
		&& ctrl.ctrl_addr_strobe_n && active_reg
		|=> active_reg && $stable(start_low_reg))
		else $error("disabled processor strobe acted");
	a_oe_gate: assert property (dq_oe |-> !out_enable_n && read_active_reg)
		else $error("drive without enable");
	a_write_cause: assert property (do_write |-> write_dec && access)
		else $error("write without write controls");
	a_read_default: assert property (access && ctrl.all_lanes_write_n
		&& (&ctrl.byte_lane_write_n) |-> !do_write)
		else $error("read turned into write");
	a_all_lanes: assert property (!ctrl.all_lanes_write_n |-> lane_en == lane_cfg)
		else $error("all-lanes write missed a lane");
	// order checks assume the order pin stays put for a whole burst
	a_interleave: assert property (cont && active_reg && burst_order
		&& !ctrl.burst_step_n |-> (acc_low ^ start_low_reg)
		== 2'((last_low ^ start_low_reg) + sbsc_pkg::COUNT_STEP))
		else $error("interleave order wrong");
	a_linear_upper: assert property (cont && active_reg
		|-> acc_addr[sbsc_pkg::ADDR_W-1:sbsc_pkg::LOW_W]
		== last_addr_reg[sbsc_pkg::ADDR_W-1:sbsc_pkg::LOW_W])
		else $error("burst moved upper address bits");
	a_reset_quiet: assert property (@(posedge clk) disable iff (1'h0)
		!rstn |=> !dq_oe)
		else $error("drive right after reset");
	a_linear_step: assert property (cont && active_reg && !burst_order
		&& !ctrl.burst_step_n |-> acc_low == 2'(last_low + sbsc_pkg::COUNT_STEP))
		else $error("linear order wrong");
	a_suspend_addr: assert property (cont && active_reg && ctrl.burst_step_n
		|-> acc_addr == last_addr_reg)
		else $error("suspend left the current address");
	a_burst_wrap: assert property (cont && active_reg && !ctrl.burst_step_n
		&& 2'(count_reg + sbsc_pkg::COUNT_STEP) == sbsc_pkg::COUNT_RST
		|-> acc_low == start_low_reg)
		else $error("fifth beat did not wrap to start");
	a_proc_addr: assert property (start_proc |-> acc_addr == ext_addr)
		else $error("processor start ignored the address");
	a_deselect_close: assert property (deselect |=> !active_reg)
		else $error("deselect left the burst open");

	// ****************************************
	// cover points
	// ****************************************
	c_ctrl_write: cover property (start_ctrl && write_dec);
	c_four_beats: cover property (start_proc ##1 (cont && !ctrl.burst_step_n)[*4]);
	c_wait_state: cover property (active_reg && cont && ctrl.burst_step_n);
	c_deselect: cover property (active_reg && deselect);
	c_linear_burst: cover property (start_ctrl && write_dec
		##1 (cont && !burst_order && !ctrl.burst_step_n)[*3]);
endmodule // sbsc_top
`default_nettype wire

/* sim/sbsc_master.sv */
// bus master model: drives the sram control pins one clock cycle at a time
// assumes the bench calls cyc and judges the outputs after it returns
`default_nettype none
module sbsc_master (
	input wire logic clk,
	output sbsc_pkg::sbsc_ctrl_t ctrl,
	output logic [sbsc_pkg::ADDR_W-1:0] ext_addr,
	output logic burst_order,
	output logic out_enable_n,
	output sbsc_pkg::sbsc_word_t dq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// cycle driver
	// ****************
	// order pin value for the next cycle; it only moves with the other pins
	logic order_pend = 1'h1;
	initial begin
		ctrl = 10'h37f;
		ext_addr = 19'h0;
		burst_order = 1'b1;
		out_enable_n = 1'b1;
		dq_in = 36'h0;
	end
	task automatic cyc(input logic [9:0] c, input logic [18:0] a, input logic [35:0] d,
		input logic oe_n);
		logic wr;
		// a processor start is a read whatever the write pins say
		wr = ((!c[5] && c[3:0] != 4'hf) || !c[4]) && (c[9] || c[8]);
		@(negedge clk);
		ctrl = c;
		ext_addr = a;
		burst_order = order_pend;
		out_enable_n = wr ? 1'b1 : oe_n;
		// released data lines toggle so stale values never match
		dq_in = wr ? d : ~dq_in;
		@(posedge clk);
		#1;
	endtask
	// order change waits for the next driven cycle
	task automatic set_order(input logic o);
		order_pend = o;
	endtask
	// enable released between edges, at the falling edge
	task automatic release_oe();
		@(negedge clk);
		out_enable_n = 1'h1;
		#1;
	endtask
endmodule // sbsc_master
`default_nettype wire

/* sim/sync_burst_sram_control_test.sv */
// self-checking bench for the burst sram control block
// assumes the master model drives every control pin at the falling edge
`default_nettype none
module sync_burst_sram_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// harness
	// ****************
	logic clk = 1'b0;
	logic rstn = 1'b0;
	sbsc_pkg::sbsc_ctrl_t ctrl;
	logic [sbsc_pkg::ADDR_W-1:0] ext_addr;
	logic burst_order, out_enable_n, dq_oe;
	sbsc_pkg::sbsc_word_t dq_in, dq_out;
	int fail_count = 0;
	int cmp_count = 0;
	logic [35:0] mem_exp [4];
	always #10 clk = ~clk;
	sbsc_top i_sbsc_top (.clk(clk), .rstn(rstn), .ctrl(ctrl), .ext_addr(ext_addr),
		.burst_order(burst_order), .out_enable_n(out_enable_n), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe));
	sbsc_master i_sbsc_master (.clk(clk), .ctrl(ctrl), .ext_addr(ext_addr),
		.burst_order(burst_order), .out_enable_n(out_enable_n), .dq_in(dq_in));
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic test_reset();
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk("drive after reset", 36'h0, {35'h0, dq_oe});
		i_sbsc_master.cyc(10'h1bf, 19'h0, 36'h0, 1'b0);
		chk("continue without burst", 36'h0, {35'h0, dq_oe});
	endtask
	task automatic test_burst();
		logic [9:0] cmd;
		i_sbsc_master.set_order(1'h0);
		for (int i = 0; i < 4; i++) begin
			mem_exp[(i + 1) % 4] = 36'h5_a5a5_0000 + 36'(i);
			// controller write start, then linear write beats
			cmd = (i == 0) ? 10'h16f : 10'h1af;
			i_sbsc_master.cyc(cmd, 19'h00101, mem_exp[(i + 1) % 4], 1'h1);
		end
		i_sbsc_master.set_order(1'h1);
		i_sbsc_master.cyc(10'h0c0, 19'h00102, 36'h0, 1'b0);
		chk("processor start read", mem_exp[2], dq_out);
		chk("read drive", 36'h1, {35'h0, dq_oe});
		// upper address moved on purpose: the burst must keep its own
		i_sbsc_master.cyc(10'h2bf, 19'h0, 36'h0, 1'b0);
		chk("advance chip off", mem_exp[3], dq_out);
		i_sbsc_master.cyc(10'h1ff, 19'h0, 36'h0, 1'b0);
		chk("suspend", mem_exp[3], dq_out);
		for (int i = 2; i < 5; i++) begin
			i_sbsc_master.cyc(10'h1bf, 19'h0, 36'h0, 1'b0);
			chk("interleaved beat", mem_exp[2'(i) ^ 2'h2], dq_out);
		end
	endtask
	task automatic test_lanes();
		i_sbsc_master.cyc(10'h16f, 19'h00200, 36'h0, 1'b1);
		i_sbsc_master.cyc(10'h1de, 19'h0, 36'hf_ffff_ffff, 1'b1);
		i_sbsc_master.cyc(10'h1df, 19'h0, 36'h0, 1'b0);
		chk("lane a only", 36'h1_0000_00ff, dq_out);
		i_sbsc_master.release_oe();
		chk("enable released", 36'h0, {35'h0, dq_oe});
		i_sbsc_master.cyc(10'h37f, 19'h0, 36'h0, 1'b0);
		chk("deselect", 36'h0, {35'h0, dq_oe});
		i_sbsc_master.cyc(10'h0c0, 19'h00300, 36'h0, 1'b0);
		i_sbsc_master.cyc(10'h1ef, 19'h0, 36'h3_1234_5678, 1'b1);
		i_sbsc_master.cyc(10'h17f, 19'h00300, 36'h0, 1'b0);
		chk("write after processor start", 36'h3_1234_5678, dq_out);
	endtask
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		test_reset();
		test_burst();
		test_lanes();
		report_and_stop();
	end
endmodule // sync_burst_sram_control_test
`default_nettype wire
